// *** verilog/dacis_top.sv ***
/*
  Two-wire slave command port of a 16-bit converter: addressing, write updates, read-back.
  Assumes an open-drain bus resolved outside; sdaOe high pulls the data line low.
*/
`timescale 1ns/10ps
module dacis_top #(
  parameter int DATA_BITS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelPin,
  output logic [15:0] convData,
  output logic [15:0] tempData,
  output dacis_pkg::dacis_pwr_t powerMode,
  output logic highSpeed,
  output logic updatePulse
);
  import dacis_pkg::*;

  if (DATA_BITS != 2 * BYTE_BITS) begin : gBadWidth
    $error("dacis_top serves exactly two data bytes");
  end

  dacis_line_if line ();

  dacis_line_sync #(.STAGES(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .addrSelPin(addrSelPin),
    .line(line)
  );

  //////////////////////////////////////////////////////////////////////////////
  dacis_phase_t phase_q;
  dacis_phase_t nextPh_q;
  dacis_role_t role_q;
  dacis_pwr_t pwr_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] txByte_q;
  logic [7:0] ctrl_q;
  logic [7:0] hiByte_q;
  logic [7:0] loByte_q;
  logic [15:0] conv_q;
  logic [15:0] temp_q;
  logic tempPd_q;
  logic ackGo_q;
  logic sdaOe_q;
  logic updPend_q;
  logic hs_q;
  logic upd_q;
  logic addrBit_q;
  logic [1:0] capCnt_q;

  function automatic dacis_pwr_t pwrDecode(input logic [2:0] code);
    dacis_pwr_t res;
    res = PWR_LOW;
    unique case (code[2:1])
      2'h0: res = code[0] ? PWR_FAST : PWR_LOW;
      2'h1: res = PWR_PD_1K;
      2'h2: res = PWR_PD_100K;
      2'h3: res = PWR_HIZ;
    endcase
    return res;
  endfunction : pwrDecode

  //////////////////////////////////////////////////////////////////////////////
  wire [7:0] rxByte = {shift_q[6:0], line.sdaLevel};
  wire rxDone = line.sclRise && (phase_q == PH_RX) && (bitCnt_q == 4'h7);
  wire ownMatch = (rxByte[7:3] == ADDR_PRESET) && (rxByte[2] == addrBit_q) && !rxByte[1];
  wire bcastMatch = (rxByte == BCAST_ADDR);
  wire masterCode = (rxByte[7:3] == HS_CODE_PREFIX);
  wire addrAck = ownMatch || bcastMatch;
  wire readReq = ownMatch && rxByte[0];
  wire txAckSeen = line.sclRise && (phase_q == PH_TXACK) && !line.sdaLevel;
  wire [1:0] ctrlMode = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
  wire pdFlag = ctrl_q[CTRL_PD];
  wire brcSel = ctrl_q[CTRL_BRC];
  wire ignoreUpd = (ctrl_q[CTRL_IGN_HI:CTRL_IGN_LO] != 2'h0) && (ctrlMode != MODE_BCAST);
  wire updFire = line.sclFall && (phase_q == PH_RXACK) && updPend_q;
  wire fromTemp = (ctrlMode == MODE_TEMP) || ((ctrlMode == MODE_BCAST) && !brcSel);
  wire storeTemp = !ignoreUpd && (ctrlMode != MODE_TEMP) && !fromTemp;
  wire loadConv = !ignoreUpd && (ctrlMode != MODE_STORE);
  wire [15:0] dataWord = {hiByte_q, loByte_q};
  wire [15:0] srcWord = fromTemp ? temp_q : dataWord;
  wire srcPd = fromTemp ? tempPd_q : pdFlag;
  wire [2:0] txIdx = 3'(4'h7 - bitCnt_q);

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;
  assign convData = conv_q;
  assign tempData = temp_q;
  assign powerMode = pwr_q;
  assign highSpeed = hs_q;
  assign updatePulse = upd_q;

  //////////////////////////////////////////////////////////////////////////////
  // The select pin is caught once the synchroniser holds real pin samples.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capCnt_q <= 2'h0;
      addrBit_q <= 1'b0;
    end else if (capCnt_q != CAP_WAIT) begin
      capCnt_q <= capCnt_q + 2'h1;
      addrBit_q <= line.addrSelLevel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit engine: the data line only changes after a falling clock is seen.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      sdaOe_q <= 1'b0;
    end else if (line.stopSeen) begin
      phase_q <= PH_IDLE;
      sdaOe_q <= 1'b0;
    end else if (line.startSeen) begin
      phase_q <= PH_RX;
      bitCnt_q <= 4'h0;
      sdaOe_q <= 1'b0;
    end else begin
      unique case (phase_q)
        PH_IDLE: begin
        end
        PH_RX: begin
          if (line.sclRise) begin
            shift_q <= rxByte;
            bitCnt_q <= bitCnt_q + 4'h1;
            if (bitCnt_q == 4'h7) begin
              phase_q <= PH_WAITACK;
            end
          end
        end
        PH_WAITACK: begin
          if (line.sclFall) begin
            sdaOe_q <= ackGo_q;
            phase_q <= PH_RXACK;
          end
        end
        PH_RXACK: begin
          if (line.sclFall) begin
            bitCnt_q <= 4'h0;
            phase_q <= nextPh_q;
            sdaOe_q <= (nextPh_q == PH_TX) && !txByte_q[7];
          end
        end
        PH_TX: begin
          if (line.sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (line.sclFall) begin
            if (bitCnt_q == 4'h8) begin
              sdaOe_q <= 1'b0;
              phase_q <= PH_TXACK;
            end else begin
              sdaOe_q <= !txByte_q[txIdx];
            end
          end
        end
        PH_TXACK: begin
          if (line.sclRise) begin
            // A nack, or any answer after the control byte, ends the read.
            phase_q <= (txAckSeen && role_q != ROLE_CTRL) ? PH_TXGO : PH_IDLE;
          end
        end
        PH_TXGO: begin
          if (line.sclFall) begin
            bitCnt_q <= 4'h0;
            sdaOe_q <= !txByte_q[7];
            phase_q <= PH_TX;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte roles: address, control, then high/low pairs until stop or restart.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      role_q <= ROLE_ADDR;
      nextPh_q <= PH_IDLE;
      ackGo_q <= 1'b0;
      hs_q <= 1'b0;
      updPend_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      hiByte_q <= 8'h00;
      loByte_q <= 8'h00;
      txByte_q <= 8'h00;
    end else begin
      if (line.stopSeen) begin
        hs_q <= 1'b0;
      end
      if (line.startSeen) begin
        role_q <= ROLE_ADDR;
        updPend_q <= 1'b0;
      end else if (updFire) begin
        updPend_q <= 1'b0;
      end
      if (rxDone) begin
        unique case (role_q)
          ROLE_ADDR: begin
            ackGo_q <= addrAck;
            if (masterCode) begin
              hs_q <= 1'b1;
            end
            if (readReq) begin
              nextPh_q <= PH_TX;
              role_q <= ROLE_HI;
              txByte_q <= hiByte_q;
            end else if (addrAck) begin
              nextPh_q <= PH_RX;
              role_q <= ROLE_CTRL;
            end else begin
              nextPh_q <= PH_IDLE;
            end
          end
          ROLE_CTRL: begin
            ackGo_q <= 1'b1;
            nextPh_q <= PH_RX;
            ctrl_q <= rxByte;
            role_q <= ROLE_HI;
          end
          ROLE_HI: begin
            ackGo_q <= 1'b1;
            nextPh_q <= PH_RX;
            hiByte_q <= rxByte;
            role_q <= ROLE_LO;
          end
          ROLE_LO: begin
            ackGo_q <= 1'b1;
            nextPh_q <= PH_RX;
            loByte_q <= rxByte;
            updPend_q <= 1'b1;
            role_q <= ROLE_HI;
          end
        endcase
      end
      if (txAckSeen) begin
        if (role_q == ROLE_HI) begin
          role_q <= ROLE_LO;
          txByte_q <= loByte_q;
        end else if (role_q == ROLE_LO) begin
          role_q <= ROLE_CTRL;
          txByte_q <= ctrl_q;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Update datapath; a power command never touches the conversion data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_q <= CONV_RESET;
      temp_q <= TEMP_RESET;
      tempPd_q <= 1'b0;
      pwr_q <= PWR_LOW;
      upd_q <= 1'b0;
    end else begin
      upd_q <= updFire;
      if (updFire && storeTemp) begin
        temp_q <= dataWord;
        tempPd_q <= pdFlag;
      end
      if (updFire && loadConv) begin
        if (srcPd) begin
          pwr_q <= pwrDecode(srcWord[PWR_HI:PWR_LO]);
        end else begin
          conv_q <= srcWord;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  AST_MASTER_CODE_NO_ACK: assert property (@(posedge clk) disable iff (rst)
    rxDone && role_q == ROLE_ADDR && masterCode |=> !ackGo_q && hs_q)
    else $error("master code was acknowledged or did not enter high speed");

  AST_STOP_LEAVES_HS: assert property (@(posedge clk) disable iff (rst)
    line.stopSeen |=> !hs_q [*2])
    else $error("high speed survived a stop");

  AST_OWN_ADDR_ACK: assert property (@(posedge clk) disable iff (rst)
    rxDone && role_q == ROLE_ADDR && ownMatch |=> ackGo_q && role_q != ROLE_ADDR)
    else $error("own address not acknowledged");

  AST_FOREIGN_RELEASE: assert property (@(posedge clk) disable iff (rst)
    rxDone && role_q == ROLE_ADDR && !ownMatch && !bcastMatch
      |=> !ackGo_q && nextPh_q == PH_IDLE)
    else $error("foreign address drew an acknowledge");

  AST_BCAST_READ_REFUSED: assert property (@(posedge clk) disable iff (rst)
    rxDone && role_q == ROLE_ADDR && rxByte == (BCAST_ADDR | 8'h01) |=> !ackGo_q)
    else $error("broadcast read was acknowledged");

  AST_UPDATE_AT_ACK_FALL: assert property (@(posedge clk) disable iff (rst)
    upd_q |-> $past(line.sclFall) && $past(phase_q) == PH_RXACK)
    else $error("update not at the falling edge ending the ack");

  AST_BAD_CTRL_IGNORED: assert property (@(posedge clk) disable iff (rst)
    updFire && ignoreUpd |=> $stable(conv_q) && $stable(temp_q) && $stable(pwr_q))
    else $error("update happened despite nonzero top control bits");

  AST_STORE_ONLY: assert property (@(posedge clk) disable iff (rst)
    updFire && !ignoreUpd && ctrlMode == MODE_STORE
      |=> $stable(conv_q) && temp_q == $past(dataWord))
    else $error("store mode changed the output or missed the temporary register");

  AST_LOAD_DATA: assert property (@(posedge clk) disable iff (rst)
    updFire && !ignoreUpd && ctrlMode == MODE_LOAD && !pdFlag
      |=> conv_q == $past(dataWord) && temp_q == $past(dataWord))
    else $error("load mode did not write both registers");

  AST_LOAD_FROM_TEMP: assert property (@(posedge clk) disable iff (rst)
    updFire && !ignoreUpd && ctrlMode == MODE_TEMP && !tempPd_q
      |=> conv_q == $past(temp_q) && $stable(temp_q))
    else $error("temporary load did not copy the temporary register");

endmodule : dacis_top

// *** verilog/dacis_pkg.sv ***
/*
  Constants, encodings and state types of the converter's two-wire slave command port.
  Assumes a single system clock that samples the serial clock and data pins as plain inputs.
*/
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Master code is never acknowledged but switches the front end to high speed.
// - A stop leaves high-speed operation and restores standard/fast settings.
// - A read sends high byte, then low byte and control byte, each after master ack.
// - Read-back data bytes and the control byte together tell which source was sent.
// - Write needs address, control, high and low byte; each byte is acked low.
// - The update fires at the falling clock edge ending the ack after the low byte.
// - Further high/low pairs repeat the update chosen by the latest control byte.
// - Own address is 10011, select pin bit, zero, then the direction bit.
// - The select pin is caught once after power-up and used from then on.
// - Direction bit one reads from the device, zero writes to it.
// - The broadcast address is also acknowledged whatever the select pin holds.
// - Broadcast address is accepted for writes only, never for reads.
// - Nonzero top control bits outside broadcast mode block the update, bytes still acked.
// - Mode 00 stores data or power command in the temporary register only.
// - Mode 01 writes the temporary register and the conversion register, or the power setting when the power-down flag is set.
// - Mode 10 drops the received bytes and loads from the temporary register.
// - Mode 11 loads from temporary when source bit zero, from received data when one.
// - With the power-down flag set, high-byte top three bits are a power setting.
// - Store mode with power-down flag saves the power command without applying it.
// - Broadcast with source and power-down flags applies the carried power setting.
// - Power codes: 000 low power, 001 fast, 01x 1k, 10x 100k, 11x high impedance.
// - At power-up the conversion register is zero until a valid write.
//////////////////////////////////////////////////////////////////////////////
package dacis_pkg;

  localparam logic [4:0] ADDR_PRESET = 5'h13;
  localparam logic [7:0] BCAST_ADDR = 8'h90;
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
  localparam int BYTE_BITS = 8;

  localparam int CTRL_IGN_HI = 7;
  localparam int CTRL_IGN_LO = 6;
  localparam int CTRL_MODE_HI = 5;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_BRC = 2;
  localparam int CTRL_PD = 0;
  localparam int PWR_HI = 15;
  localparam int PWR_LO = 13;

  localparam logic [1:0] MODE_STORE = 2'h0;
  localparam logic [1:0] MODE_LOAD = 2'h1;
  localparam logic [1:0] MODE_TEMP = 2'h2;
  localparam logic [1:0] MODE_BCAST = 2'h3;

  localparam logic [15:0] CONV_RESET = 16'h0000;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] SYNC_IDLE = 3'h3;
  localparam logic [1:0] CAP_WAIT = 2'h3;

  typedef enum logic [2:0] {
    PH_IDLE, PH_RX, PH_WAITACK, PH_RXACK, PH_TX, PH_TXACK, PH_TXGO
  } dacis_phase_t;

  typedef enum logic [1:0] {ROLE_ADDR, ROLE_CTRL, ROLE_HI, ROLE_LO} dacis_role_t;

  typedef enum logic [2:0] {
    PWR_LOW, PWR_FAST, PWR_PD_1K, PWR_PD_100K, PWR_HIZ
  } dacis_pwr_t;

endpackage : dacis_pkg

// *** verilog/dacis_line_if.sv ***
/*
  Carrier between the pin synchroniser and the command engine.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface dacis_line_if;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaLevel;
  logic addrSelLevel;

  modport det (
    output sclRise,
    output sclFall,
    output startSeen,
    output stopSeen,
    output sdaLevel,
    output addrSelLevel
  );

  modport core (
    input sclRise,
    input sclFall,
    input startSeen,
    input stopSeen,
    input sdaLevel,
    input addrSelLevel
  );
endinterface : dacis_line_if

// *** verilog/dacis_line_sync.sv ***
/*
  Pin synchroniser and bus-condition detector for the serial clock, data and select pins.
  Assumes pins are asynchronous to clk and the clock is many times the serial bit rate.
*/
`timescale 1ns/10ps
module dacis_line_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic addrSelPin,
  dacis_line_if.det line
);
  import dacis_pkg::*;

  // Refused while the design is built, before any clock runs.
  if (STAGES < 2) begin : gBadStages
    $error("dacis_line_sync needs at least two synchroniser stages");
  end

  // Bit 0 is the clock, bit 1 the data, bit 2 the select pin.
  logic [2:0] sync_q [STAGES];
  logic [2:0] prev_q;
  wire [2:0] cur = sync_q[STAGES-1];

  // Reset to the idle bus level so no false start or edge follows reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) begin
        sync_q[i] <= SYNC_IDLE;
      end
      prev_q <= SYNC_IDLE;
    end else begin
      sync_q[0] <= {addrSelPin, sdaIn, sclIn};
      for (int i = 1; i < STAGES; i++) begin
        sync_q[i] <= sync_q[i-1];
      end
      prev_q <= cur;
    end
  end

  assign line.sclRise = cur[0] & ~prev_q[0];
  assign line.sclFall = ~cur[0] & prev_q[0];
  assign line.startSeen = cur[0] & prev_q[0] & prev_q[1] & ~cur[1];
  assign line.stopSeen = cur[0] & prev_q[0] & ~prev_q[1] & cur[1];
  assign line.sdaLevel = cur[1];
  assign line.addrSelLevel = cur[2];

endmodule : dacis_line_sync

// *** tb/dacis_bus_master.sv ***
/*
  Bus master model for the converter's two-wire command port: start, stop and byte transfers.
  Assumes the bench resolves the open-drain data line with a pull-up into sdaLine.
*/
`timescale 1ns/10ps
module dacis_bus_master (
  output logic scl,
  output logic sdaPull,
  input wire logic sdaLine
);
  // Quarter of the 125 ns bus clock period.
  localparam realtime QTR = 31.25;

  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data changes a quarter period after the clock falls so the slave never sees it move
  // while the clock is still high through its synchroniser.
  task automatic bit_io(input logic b, output logic r);
    #QTR sdaPull = !b;
    #QTR scl = 1'b1;
    #QTR r = sdaLine;
    #QTR scl = 1'b0;
  endtask : bit_io

  // Works from idle and as a repeated start after a byte.
  task automatic start_cond();
    #QTR sdaPull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sdaPull = 1'b1;
    #QTR scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #QTR sdaPull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sdaPull = 1'b0;
    #QTR;
  endtask : stop_cond

  // The ninth bit is driven from ackOut: 0 acknowledges, 1 releases the line.
  task automatic xfer(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
                      output logic ackIn);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ackOut, r);
    ackIn = !r;
  endtask : xfer
endmodule : dacis_bus_master

// *** tb/test_dac_i2c_slave_command_port.sv ***
/*
  Self-checking bench of the converter's two-wire slave command port.
  Assumes the bus master model and a pulled-up data line; the select pin is low unless stated.
*/
`timescale 1ns/10ps
module test_dac_i2c_slave_command_port;
  import dacis_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] ctrl;
    logic [15:0] data;
    logic ack;
    logic [15:0] conv;
    logic [15:0] temp;
    dacis_pwr_t pwr;
  } dacis_row_t;

  localparam int NROWS = 17;
  localparam int LIMIT = 90000;
  localparam logic [15:0] NA = 16'hxxxx;
  // Control bits three and one stay zero in every row.
  localparam dacis_row_t ROWS [NROWS] = '{
    '{8'h98, 8'h00, 16'h1234, 1'b1, 16'h0000, 16'h1234, PWR_LOW},
    '{8'h98, 8'h10, 16'h4000, 1'b1, 16'h4000, 16'h4000, PWR_LOW},
    '{8'h98, 8'h00, 16'hFFFF, 1'b1, 16'h4000, 16'hFFFF, PWR_LOW},
    '{8'h98, 8'h20, 16'h5555, 1'b1, 16'hFFFF, 16'hFFFF, PWR_LOW},
    '{8'h98, 8'hD0, 16'h1111, 1'b1, 16'hFFFF, 16'hFFFF, PWR_LOW},
    '{8'h9C, 8'h10, 16'h2222, 1'b0, 16'hFFFF, 16'hFFFF, PWR_LOW},
    '{8'h9A, 8'h10, 16'h2222, 1'b0, 16'hFFFF, 16'hFFFF, PWR_LOW},
    '{8'h90, 8'hF4, 16'h2222, 1'b1, 16'h2222, 16'h2222, PWR_LOW},
    '{8'h98, 8'h00, 16'h3333, 1'b1, 16'h2222, 16'h3333, PWR_LOW},
    '{8'h90, 8'h30, 16'hABCD, 1'b1, 16'h3333, 16'h3333, PWR_LOW},
    '{8'h98, 8'h11, 16'h2000, 1'b1, 16'h3333, 16'h2000, PWR_FAST},
    '{8'h98, 8'h11, 16'h6000, 1'b1, 16'h3333, 16'h6000, PWR_PD_1K},
    '{8'h98, 8'h11, 16'hA000, 1'b1, 16'h3333, 16'hA000, PWR_PD_100K},
    '{8'h98, 8'h11, 16'h0000, 1'b1, 16'h3333, 16'h0000, PWR_LOW},
    '{8'h98, 8'h01, 16'hE000, 1'b1, 16'h3333, 16'hE000, PWR_LOW},
    '{8'h98, 8'h20, 16'h0000, 1'b1, 16'h3333, 16'hE000, PWR_HIZ},
    '{8'h90, 8'h35, 16'h8000, 1'b1, 16'h3333, 16'h8000, PWR_PD_100K}
  };

  logic clk, rst, addrSelPin, sdaOut, sdaOe, highSpeed, updatePulse, scl, sdaPull, sdaLine, ack;
  logic [15:0] convData, tempData;
  logic [7:0] rx;
  dacis_pwr_t powerMode;
  int errCount, checked, cycles, pulses, n;

  // Open-drain wire: either party pulls low, the pull-up wins otherwise.
  assign sdaLine = (sdaOe ? sdaOut : 1'b1) & !sdaPull;

  dacis_top i_dut (
    .clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelPin(addrSelPin), .convData(convData), .tempData(tempData),
    .powerMode(powerMode), .highSpeed(highSpeed), .updatePulse(updatePulse)
  );

  dacis_bus_master i_mst (.scl(scl), .sdaPull(sdaPull), .sdaLine(sdaLine));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Sampled on the falling edge so the one-cycle pulse is settled when counted.
  always @(negedge clk) begin
    if (updatePulse === 1'b1) pulses++;
    cycles++;
    if (cycles == LIMIT) begin
      errCount++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (errCount == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] addr, input logic [7:0] ctrl, input logic [15:0] data,
                      input logic ackExp);
    logic [31:0] seq;
    seq = {addr, ctrl, data};
    i_mst.start_cond();
    for (int i = 3; i >= 0; i--) begin
      i_mst.xfer(seq[8*i +: 8], 1'b1, rx, ack);
      check(16'(ack), 16'(ackExp));
    end
    i_mst.stop_cond();
    repeat (8) @(negedge clk);
  endtask : send

  task automatic do_reset(input logic pin);
    rst = 1'b1;
    addrSelPin = pin;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check(convData, 16'h0000);
    check(tempData, 16'h0000);
    check(16'(powerMode), 16'(PWR_LOW));
    check({highSpeed, sdaOe, 14'h0000}, 16'h0000);
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    errCount = 0;
    checked = 0;
    cycles = 0;
    pulses = 0;
    do_reset(1'b0);
    for (int i = 0; i < NROWS; i++) begin
      send(ROWS[i].addr, ROWS[i].ctrl, ROWS[i].data, ROWS[i].ack);
      check(convData, ROWS[i].conv);
      if (ROWS[i].temp !== NA) check(tempData, ROWS[i].temp);
      check(16'(powerMode), 16'(ROWS[i].pwr));
    end
    // Back-to-back pairs under one control byte, each firing its own update.
    i_mst.start_cond();
    i_mst.xfer(8'h98, 1'b1, rx, ack);
    i_mst.xfer(8'h10, 1'b1, rx, ack);
    for (int k = 1; k <= 3; k++) begin
      n = pulses;
      i_mst.xfer(8'h00, 1'b1, rx, ack);
      i_mst.xfer(8'(k), 1'b1, rx, ack);
      repeat (8) @(negedge clk);
      check(convData, 16'(k));
      check(16'(pulses - n), 16'h0001);
    end
    i_mst.stop_cond();
    // Read-back returns the last pair and the last control byte.
    i_mst.start_cond();
    i_mst.xfer(8'h99, 1'b1, rx, ack);
    check(16'(ack), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      i_mst.xfer(8'hFF, i == 2, rx, ack);
      check(16'(rx), 16'(8'(24'h00_0310 >> (8 * (2 - i)))));
    end
    i_mst.stop_cond();
    // A lone high byte before stop must not update.
    n = pulses;
    i_mst.start_cond();
    i_mst.xfer(8'h98, 1'b1, rx, ack);
    i_mst.xfer(8'h10, 1'b1, rx, ack);
    i_mst.xfer(8'h77, 1'b1, rx, ack);
    i_mst.stop_cond();
    repeat (8) @(negedge clk);
    check(16'(pulses - n), 16'h0000);
    check(convData, 16'h0003);
    // High-speed entry, broadcast read refused, stop leaves high speed.
    i_mst.start_cond();
    i_mst.xfer(8'h08, 1'b1, rx, ack);
    check(16'(ack), 16'h0000);
    check(16'(highSpeed), 16'h0001);
    i_mst.start_cond();
    i_mst.xfer(8'h91, 1'b1, rx, ack);
    check(16'(ack), 16'h0000);
    i_mst.stop_cond();
    repeat (8) @(negedge clk);
    check(16'(highSpeed), 16'h0000);
    // Second reset with the select pin high; later pin moves must not change the address.
    @(negedge clk);
    do_reset(1'b1);
    addrSelPin = 1'b0;
    send(8'h9C, 8'h10, 16'h00AA, 1'b1);
    check(convData, 16'h00AA);
    send(8'h98, 8'h10, 16'h0055, 1'b0);
    check(convData, 16'h00AA);
    send(8'h90, 8'h34, 16'h0BB0, 1'b1);
    check(convData, 16'h0BB0);
    check(tempData, 16'h0BB0);
    end_sim();
  end

  initial begin
    rst = 1'b1;
    addrSelPin = 1'b0;
  end
endmodule : test_dac_i2c_slave_command_port
